/* fcc_pkg.sv */
// Constants and types for the flash CRC-64 check engine
package fcc_pkg;
  localparam logic [7:0]  OP_ACTIVATE  = 8'h9B;
  localparam logic [7:0]  SUB_CRC      = 8'h27;
  localparam logic [7:0]  SCOPE_FULL   = 8'hFF;
  localparam logic [7:0]  SCOPE_RANGE  = 8'hFE;
  localparam logic [7:0]  OP_RD_BUF    = 8'h96;
  localparam logic [63:0] CRC_POLY     = 64'h42F0_E1EB_A9EA_3693;
  localparam logic [63:0] CRC_INIT     = 64'h0000_0000_0000_0000;
  localparam logic [63:0] BUF_RST      = 64'h0000_0000_0000_0000;
  localparam int          FLAG_CRC_BIT = 4;
  localparam int          BUF_BYTES    = 8;
  localparam logic [6:0]  IDX_EXP0     = 7'h03;
  localparam logic [6:0]  IDX_START0   = 7'h0B;
  localparam logic [6:0]  IDX_STOP0    = 7'h0F;
  localparam logic [6:0]  LEN_FULL     = 7'h0B;
  localparam logic [6:0]  LEN_RANGE    = 7'h13;
  localparam logic [6:0]  IDX_MAX      = 7'h7F;
  localparam logic [2:0]  SYNC_RST     = 3'h2;
  localparam logic [31:0] ARRAY_LAST   = 32'h03FF_FFFF;

  typedef enum logic [1:0] {
    FCC_IDLE  = 2'b00,
    FCC_FETCH = 2'b01,
    FCC_CHECK = 2'b10
  } fcc_state_t;
endpackage : fcc_pkg

/* fcc_crc_if.sv */
// Link between the check sequencer and the CRC-64 engine
`timescale 1ns/100ps
`default_nettype none
interface fcc_crc_if;
  logic        clr;
  logic        byte_vld;
  logic [7:0]  data;
  logic [63:0] crc;

  modport ctl (output clr, output byte_vld, output data, input crc);
  modport eng (input clr, input byte_vld, input data, output crc);
endinterface : fcc_crc_if
`default_nettype wire

/* fcc_crc_engine.sv */
// Byte-wide CRC-64 engine, one byte per clock
`timescale 1ns/100ps
`default_nettype none
module fcc_crc_engine
  import fcc_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  fcc_crc_if.eng    crc_if
);
  logic [63:0] crc_ff;
  logic [63:0] nxt_crc;

  function automatic logic [63:0] crc_step(input logic [63:0] c,
                                           input logic [7:0]  d);
    logic [63:0] r;
    logic        fb;
    r  = c;
    fb = 1'b0;
    for (int b = 0; b < 8; b++) begin
      fb = r[63] ^ d[b];
      r  = {r[62:0], 1'b0} ^ (fb ? CRC_POLY : 64'h0);
    end
    return r;
  endfunction : crc_step

  always_comb begin
    nxt_crc = crc_ff;
    if (crc_if.clr) begin
      nxt_crc = CRC_INIT;
    end else if (crc_if.byte_vld) begin
      nxt_crc = crc_step(crc_ff, crc_if.data);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crc_ff <= CRC_INIT;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  assign crc_if.crc = crc_ff;
endmodule : fcc_crc_engine
`default_nettype wire

/* fcc_check_top.sv */
// Serial-link CRC-64 integrity check with readback buffer
//
// Behaviour
// - CRC-64 with the ECMA degree-64 polynomial over selected bytes.
// - Each memory byte enters the CRC least significant bit first.
// - Every computation starts from an all-zero CRC value.
// - Result is compared with the host's expected 64-bit value.
// - Pass or fail shows in flag status bit 4.
// - Buffer captures computed CRC only on failure; zero after a pass.
// - Opcode 96h returns the buffer, least significant byte first.
// - Buffer cleared to zero at the start of every check.
// - Buffer cleared at power-up, hardware reset and software reset.
// - Buffer read begins at first byte; beyond the end returns 00h.
// - Second byte 27h selects the checksum function.
// - Scope byte FFh checks the whole array.
// - Check starts only at chip select rise after a complete sequence.
// - Scope FEh adds four-byte start and stop addresses, lowest first.
// - Range check covers start through stop inclusive.
`timescale 1ns/100ps
`default_nettype none
module fcc_check_top
  import fcc_pkg::*;
#(
  parameter logic [31:0] LAST_ADDR = ARRAY_LAST
) (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        sw_rst_i,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_csn_i,
  input  wire logic        spi_si_i,
  output logic             spi_so_o,
  output logic             spi_so_oe_o,
  output logic             mem_req_o,
  output logic [31:0]      mem_addr_o,
  input  wire logic [7:0]  mem_data_i,
  input  wire logic        mem_valid_i,
  output logic             busy_o,
  output logic [7:0]       flag_status_o
);
  // Refused at elaboration: a last address of zero, which would leave a one-byte array
  if (LAST_ADDR == 32'h0) begin : g_last_chk
    $error("LAST_ADDR must be above zero");
  end

  fcc_crc_if crc_if ();

  fcc_crc_engine u_engine (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .crc_if (crc_if)
  );

  // Link pins come from the host's clock domain
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [1:0] prev_ff;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
      prev_ff  <= SYNC_RST[2:1];
    end else begin
      sync1_ff <= {spi_sck_i, spi_csn_i, spi_si_i};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff[2:1];
    end
  end

  logic sck_s;
  logic csn_s;
  logic si_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  assign sck_s    = sync2_ff[2];
  assign csn_s    = sync2_ff[1];
  assign si_s     = sync2_ff[0];
  assign sck_rise = sck_s & ~prev_ff[1] & ~csn_s;
  assign sck_fall = ~sck_s & prev_ff[1] & ~csn_s;
  assign cs_rise  = csn_s & ~prev_ff[0];

  function automatic logic [7:0] rd_byte(input logic [63:0] b,
                                         input logic [6:0]  i);
    logic [7:0] r;
    r = 8'h00;
    if (i >= 7'h01 && i <= 7'(BUF_BYTES)) begin
      r = b[8*(32'(i) - 1) +: 8];
    end
    return r;
  endfunction : rd_byte

  // Command shifter and decoder
  logic [2:0]  bit_ff,   nxt_bit;
  logic [6:0]  idx_ff,   nxt_idx;
  logic [6:0]  rx_ff,    nxt_rx;
  logic        crc_cmd_ff, nxt_crc_cmd;
  logic        rng_ff,   nxt_rng;
  logic        rd_ff,    nxt_rd;
  logic [63:0] exp_ff,   nxt_exp;
  logic [31:0] first_ff, nxt_first;
  logic [31:0] last_ff,  nxt_last;
  logic        so_ff,    nxt_so;
  logic        oe_ff,    nxt_oe;
  logic        start;
  logic [7:0]  rxb;
  logic [7:0]  txb;
  logic [63:0] buf_ff;

  assign rxb = {rx_ff, si_s};
  assign txb = rd_byte(buf_ff, idx_ff);

  fcc_state_t  state_ff, nxt_state;

  always_comb begin
    nxt_bit     = bit_ff;
    nxt_idx     = idx_ff;
    nxt_rx      = rx_ff;
    nxt_crc_cmd = crc_cmd_ff;
    nxt_rng     = rng_ff;
    nxt_rd      = rd_ff;
    nxt_exp     = exp_ff;
    nxt_first   = first_ff;
    nxt_last    = last_ff;
    nxt_so      = so_ff;
    nxt_oe      = oe_ff;
    start       = 1'b0;
    if (csn_s) begin
      // Sequence length is judged at the deselect edge
      start = cs_rise && crc_cmd_ff && bit_ff == 3'h0 && state_ff == FCC_IDLE
              && idx_ff == (rng_ff ? LEN_RANGE : LEN_FULL);
      nxt_bit     = 3'h0;
      nxt_idx     = 7'h00;
      nxt_crc_cmd = 1'b0;
      nxt_rd      = 1'b0;
      nxt_oe      = 1'b0;
      nxt_so      = 1'b0;
    end else if (sck_rise) begin
      nxt_bit = bit_ff + 3'h1;
      nxt_rx  = rxb[6:0];
      if (bit_ff == 3'h7) begin
        if (idx_ff != IDX_MAX) begin
          nxt_idx = idx_ff + 7'h01;
        end
        if (idx_ff == 7'h00) begin
          nxt_crc_cmd = (rxb == OP_ACTIVATE);
          nxt_rd      = (rxb == OP_RD_BUF);
        end else if (idx_ff == 7'h01) begin
          if (rxb != SUB_CRC) nxt_crc_cmd = 1'b0;
        end else if (idx_ff == 7'h02) begin
          if (rxb == SCOPE_FULL) begin
            nxt_rng = 1'b0;
          end else if (rxb == SCOPE_RANGE) begin
            nxt_rng = 1'b1;
          end else begin
            nxt_crc_cmd = 1'b0;
          end
        end else if (!crc_cmd_ff || state_ff != FCC_IDLE) begin
          // Running check keeps its operands; stray frames change nothing
        end else if (idx_ff < IDX_START0) begin
          nxt_exp[8*(32'(idx_ff) - 3) +: 8] = rxb;
        end else if (idx_ff < IDX_STOP0) begin
          nxt_first[8*(32'(idx_ff) - 11) +: 8] = rxb;
        end else if (idx_ff < LEN_RANGE) begin
          nxt_last[8*(32'(idx_ff) - 15) +: 8] = rxb;
        end
      end
    end else if (sck_fall && rd_ff && idx_ff != 7'h00) begin
      nxt_so = txb[~bit_ff];
      nxt_oe = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_ff     <= 3'h0;
      idx_ff     <= 7'h00;
      rx_ff      <= 7'h00;
      crc_cmd_ff <= 1'b0;
      rng_ff     <= 1'b0;
      rd_ff      <= 1'b0;
      exp_ff     <= 64'h0;
      first_ff   <= 32'h0;
      last_ff    <= 32'h0;
      so_ff      <= 1'b0;
      oe_ff      <= 1'b0;
    end else begin
      bit_ff     <= nxt_bit;
      idx_ff     <= nxt_idx;
      rx_ff      <= nxt_rx;
      crc_cmd_ff <= nxt_crc_cmd;
      rng_ff     <= nxt_rng;
      rd_ff      <= nxt_rd;
      exp_ff     <= nxt_exp;
      first_ff   <= nxt_first;
      last_ff    <= nxt_last;
      so_ff      <= nxt_so;
      oe_ff      <= nxt_oe;
    end
  end

  // Array walk, compare and result
  logic [31:0] addr_ff,  nxt_addr;
  logic [31:0] end_ff,   nxt_end;
  logic        req_ff,   nxt_req;
  logic        busy_ff,  nxt_busy;
  logic        fail_ff,  nxt_fail;
  logic [63:0] nxt_buf;
  logic        done_pass;
  logic        done_fail;

  always_comb begin
    nxt_state       = state_ff;
    nxt_addr        = addr_ff;
    nxt_end         = end_ff;
    nxt_req         = 1'b0;
    nxt_fail        = fail_ff;
    nxt_buf         = buf_ff;
    crc_if.clr      = 1'b0;
    crc_if.byte_vld = 1'b0;
    crc_if.data     = mem_data_i;
    done_pass       = 1'b0;
    done_fail       = 1'b0;
    if (sw_rst_i) begin
      nxt_state = FCC_IDLE;
      nxt_fail  = 1'b0;
      nxt_buf   = BUF_RST;
    end else begin
      case (state_ff)
        FCC_IDLE: begin
          if (start) begin
            crc_if.clr = 1'b1;
            nxt_buf    = BUF_RST;
            nxt_fail   = 1'b0;
            nxt_addr   = rng_ff ? first_ff : 32'h0;
            nxt_end    = rng_ff ? last_ff : LAST_ADDR;
            // Reversed range yields an empty check, not a wrap
            if (rng_ff && last_ff < first_ff) begin
              nxt_state = FCC_CHECK;
            end else begin
              nxt_state = FCC_FETCH;
              nxt_req   = 1'b1;
            end
          end
        end
        FCC_FETCH: begin
          nxt_req = 1'b1;
          if (mem_valid_i) begin
            crc_if.byte_vld = 1'b1;
            if (addr_ff == end_ff) begin
              nxt_req   = 1'b0;
              nxt_state = FCC_CHECK;
            end else begin
              nxt_addr = addr_ff + 32'h1;
            end
          end
        end
        FCC_CHECK: begin
          nxt_state = FCC_IDLE;
          if (crc_if.crc == exp_ff) begin
            done_pass = 1'b1;
            nxt_fail  = 1'b0;
          end else begin
            done_fail = 1'b1;
            nxt_fail  = 1'b1;
            nxt_buf   = crc_if.crc;
          end
        end
        default: begin
          nxt_state = FCC_IDLE;
        end
      endcase
    end
    nxt_busy = (nxt_state != FCC_IDLE);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= FCC_IDLE;
      addr_ff  <= 32'h0;
      end_ff   <= 32'h0;
      req_ff   <= 1'b0;
      busy_ff  <= 1'b0;
      fail_ff  <= 1'b0;
      buf_ff   <= BUF_RST;
    end else begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      end_ff   <= nxt_end;
      req_ff   <= nxt_req;
      busy_ff  <= nxt_busy;
      fail_ff  <= nxt_fail;
      buf_ff   <= nxt_buf;
    end
  end

  assign spi_so_o      = so_ff;
  assign spi_so_oe_o   = oe_ff;
  assign mem_req_o     = req_ff;
  assign mem_addr_o    = addr_ff;
  assign busy_o        = busy_ff;
  assign flag_status_o = {3'h0, fail_ff, 4'h0};

  property p_start_busy;
    @(posedge mclk_i) disable iff (!nrst_i)
    start && !sw_rst_i |=> busy_o && state_ff != FCC_IDLE;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("check did not start on deselect");

  property p_start_clear;
    @(posedge mclk_i) disable iff (!nrst_i)
    start && !sw_rst_i |=> buf_ff == 64'h0 && !flag_status_o[FLAG_CRC_BIT];
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("buffer not cleared at check start");

  property p_init_zero;
    @(posedge mclk_i) disable iff (!nrst_i)
    start && !sw_rst_i |=> crc_if.crc == 64'h0;
  endproperty
  a_init_zero: assert property (p_init_zero)
    else $error("crc not zero at start");

  property p_pass;
    @(posedge mclk_i) disable iff (!nrst_i)
    done_pass |=> buf_ff == 64'h0 && !flag_status_o[FLAG_CRC_BIT] && !busy_o;
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass left data in buffer or flag set");

  property p_fail;
    @(posedge mclk_i) disable iff (!nrst_i)
    done_fail |=> buf_ff == $past(crc_if.crc) && flag_status_o[FLAG_CRC_BIT]
                  && buf_ff != exp_ff;
  endproperty
  a_fail: assert property (p_fail)
    else $error("fail not flagged or crc not captured");

  property p_busy_state;
    @(posedge mclk_i) disable iff (!nrst_i)
    busy_o == (state_ff != FCC_IDLE);
  endproperty
  a_busy_state: assert property (p_busy_state)
    else $error("busy does not match activity");

  property p_range_addr;
    @(posedge mclk_i) disable iff (!nrst_i)
    state_ff == FCC_FETCH && mem_valid_i
      |-> mem_addr_o <= end_ff ##1 mem_addr_o <= end_ff;
  endproperty
  a_range_addr: assert property (p_range_addr)
    else $error("fetch outside requested range");

  property p_tail_zero;
    @(posedge mclk_i) disable iff (!nrst_i)
    sck_fall && rd_ff && idx_ff > 7'h08 |=> spi_so_o == 1'b0 && spi_so_oe_o;
  endproperty
  a_tail_zero: assert property (p_tail_zero)
    else $error("data after buffer end not zero");

  property p_sw_reset;
    @(posedge mclk_i) disable iff (!nrst_i)
    sw_rst_i |=> buf_ff == 64'h0 && !busy_o;
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("software reset did not clear buffer");
endmodule : fcc_check_top
`default_nettype wire

/* fcc_host_model.sv */
// Host serial controller model for the check engine link
`timescale 1ns/100ps
`default_nettype none
module fcc_host_model (
  output logic      spi_sck_o,
  output logic      spi_csn_o,
  output logic      spi_si_o,
  input  wire logic spi_so_i
);
  localparam int HALF = 32;

  // Mode 0 idle: clock low, still outside frames
  initial begin
    spi_sck_o = 1'b0;
    spi_csn_o = 1'b1;
    spi_si_o  = 1'b0;
  end

  task automatic frame_open();
    #(2 * HALF);
    spi_csn_o = 1'b0;
    #HALF;
  endtask : frame_open

  // Top n bits of d, most significant first
  task automatic put_bits(input logic [7:0] d, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      spi_si_o = d[i];
      #HALF spi_sck_o = 1'b1;
      #HALF spi_sck_o = 1'b0;
    end
  endtask : put_bits

  task automatic get_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      #HALF spi_sck_o = 1'b1;
      d[i] = spi_so_i;
      #HALF spi_sck_o = 1'b0;
    end
  endtask : get_byte

  // Released data line shows the inverse, never a stale level
  task automatic frame_close();
    #HALF spi_csn_o = 1'b1;
    spi_si_o = ~spi_si_o;
  endtask : frame_close
endmodule : fcc_host_model
`default_nettype wire

/* fcc_check_top_test.sv */
// Self-checking testbench for the CRC-64 check engine
`timescale 1ns/100ps
`default_nettype none
module fcc_check_top_test;
  import fcc_pkg::*;
  // Small array keeps each full check short
  localparam logic [31:0] LAST = 32'h0000_000F;
  typedef logic [7:0] fcc_bytes_t[$];
  typedef struct packed {
    logic [7:0]  scope;
    logic [31:0] lo;
    logic [31:0] hi;
    logic        bad;
  } fcc_row_t;

  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        sw_rst_i = 1'b0;
  logic        sck;
  logic        csn;
  logic        si;
  logic [7:0]  mem_data_i = 8'h00;
  logic        mem_valid_i = 1'b0;
  logic        spi_so_o;
  logic        spi_so_oe_o;
  logic        mem_req_o;
  logic [31:0] mem_addr_o;
  logic        busy_o;
  logic [7:0]  flag_status_o;
  logic [7:0]  mem [16];
  logic [1:0]  cnt = 2'h0;
  int          n_mismatch = 0;
  int          comparisons = 0;
  wire logic   so_line = spi_so_oe_o ? spi_so_o : 1'b1;
  fcc_row_t    rows [5] = '{
    '{SCOPE_FULL,  32'h0, LAST,  1'b0},
    '{SCOPE_RANGE, 32'h7, 32'h7, 1'b1},
    '{SCOPE_RANGE, 32'h2, 32'h5, 1'b0},
    '{SCOPE_RANGE, 32'h5, 32'h4, 1'b0},
    '{SCOPE_FULL,  32'h0, LAST,  1'b1}};

  always #2.5 mclk_i = ~mclk_i;

  fcc_check_top #(.LAST_ADDR(LAST)) dut_u (
    .mclk_i        (mclk_i),
    .nrst_i        (nrst_i),
    .sw_rst_i      (sw_rst_i),
    .spi_sck_i     (sck),
    .spi_csn_i     (csn),
    .spi_si_i      (si),
    .spi_so_o      (spi_so_o),
    .spi_so_oe_o   (spi_so_oe_o),
    .mem_req_o     (mem_req_o),
    .mem_addr_o    (mem_addr_o),
    .mem_data_i    (mem_data_i),
    .mem_valid_i   (mem_valid_i),
    .busy_o        (busy_o),
    .flag_status_o (flag_status_o)
  );

  fcc_host_model host_u (
    .spi_sck_o (sck),
    .spi_csn_o (csn),
    .spi_si_o  (si),
    .spi_so_i  (so_line)
  );

  // Array model stalls one cycle in four
  always @(posedge mclk_i) begin
    #1;
    cnt = cnt + 2'h1;
    mem_valid_i = mem_req_o & (cnt != 2'h3);
    mem_data_i = mem[mem_addr_o[3:0]];
  end

  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask : tick

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // Non-reflected register, each byte fed lsb first
  function automatic logic [63:0] ref_crc(input int lo, input int hi);
    logic [63:0] c;
    logic        fb;
    c = CRC_INIT;
    for (int a = lo; a <= hi; a++) begin
      for (int b = 0; b < 8; b++) begin
        fb = c[63] ^ mem[a][b];
        c = {c[62:0], 1'b0};
        if (fb) c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : ref_crc

  function automatic fcc_bytes_t build(input fcc_row_t r,
                                       input logic [63:0] e);
    fcc_bytes_t q;
    q = {OP_ACTIVATE, SUB_CRC, r.scope};
    for (int i = 0; i < 8; i++) q.push_back(e[8*i+:8]);
    if (r.scope == SCOPE_RANGE) begin
      for (int i = 0; i < 4; i++) q.push_back(r.lo[8*i+:8]);
      for (int i = 0; i < 4; i++) q.push_back(r.hi[8*i+:8]);
    end
    return q;
  endfunction : build

  task automatic send(input fcc_bytes_t q, input int tail);
    host_u.frame_open();
    foreach (q[i]) host_u.put_bits(q[i], 8);
    if (tail > 0) host_u.put_bits(8'hA5, tail);
    host_u.frame_close();
  endtask : send

  task automatic wait_done(input logic want);
    int n;
    n = 0;
    while (busy_o !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    check(busy_o, want);
    n = 0;
    while (busy_o !== 1'b0 && n < 500) begin
      tick();
      n++;
    end
    check(busy_o, 1'b0);
  endtask : wait_done

  // Nine bytes: the eight buffer bytes, then one past the end
  task automatic read_buf(input logic [63:0] exp);
    logic [7:0] b;
    host_u.frame_open();
    host_u.put_bits(OP_RD_BUF, 8);
    for (int i = 0; i < 9; i++) begin
      host_u.get_byte(b);
      check(b, (i < 8) ? exp[8*i+:8] : 8'h00);
    end
    host_u.frame_close();
  endtask : read_buf

  task automatic run_row(input fcc_row_t r);
    logic [63:0] c;
    c = ref_crc(int'(r.lo), int'(r.hi));
    send(build(r, r.bad ? ~c : c), 0);
    wait_done(1'b1);
    check(flag_status_o, {3'h0, r.bad, 4'h0});
    read_buf(r.bad ? c : 64'h0);
  endtask : run_row

  initial begin
    logic [7:0] hdr [3][3];
    logic [63:0] last_crc;
    fcc_bytes_t q;
    hdr = '{'{8'h9A, SUB_CRC, SCOPE_FULL}, '{OP_ACTIVATE, 8'h28, SCOPE_FULL},
            '{OP_ACTIVATE, SUB_CRC, 8'hFD}};
    for (int i = 0; i < 16; i++) mem[i] = 8'h3C + 8'(i * 23);
    repeat (2) tick();
    nrst_i = 1'b1;
    repeat (4) tick();
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("Test row %0d done", i);
    end
    last_crc = ref_crc(0, int'(LAST));
    // Malformed headers and a partial byte leave the last result alone
    for (int k = 0; k < 3; k++) begin
      q = build(rows[0], 64'h0);
      for (int j = 0; j < 3; j++) q[j] = hdr[k][j];
      send(q, 0);
      wait_done(1'b0);
    end
    send(build(rows[0], 64'h0), 4);
    wait_done(1'b0);
    check(flag_status_o, 8'h10);
    read_buf(last_crc);
    $display("Test refused sequences done");
    send(build(rows[4], ~last_crc), 0);
    while (busy_o !== 1'b1) tick();
    tick();
    sw_rst_i = 1'b1;
    tick();
    sw_rst_i = 1'b0;
    tick();
    check(busy_o, 1'b0);
    check(flag_status_o, 8'h00);
    read_buf(64'h0);
    $display("Test software reset done");
    run_row(rows[4]);
    tick();
    nrst_i = 1'b0;
    tick();
    tick();
    check({busy_o, mem_req_o, flag_status_o}, 10'h000);
    nrst_i = 1'b1;
    repeat (4) tick();
    read_buf(64'h0);
    $display("Test hardware reset done");
    print_verdict();
  end

  // Whole run needs about 125 us; limit sits at 60k cycles
  initial begin
    #300000;
    n_mismatch++;
    print_verdict();
  end
endmodule : fcc_check_top_test
`default_nettype wire
